// ### asd_cfg.svh
// address map constants for the three-space address decoder
// assumes byte addressing in every space
`ifndef ASD_CFG_SVH
`define ASD_CFG_SVH
`define ASD_RF_AW         12
`define ASD_PM_AW         16
`define ASD_DM_AW         16
`define ASD_RF_CTRL_BASE  12'hF00
`define ASD_RF_RAM_BASE   12'h000
`define ASD_RF_RAM_DEF    13'h0800
`define ASD_PM_FLASH_DEF  17'h04000
`define ASD_PM_BLANK      8'hFF
`define ASD_PM_OPT_LO     16'h0000
`define ASD_PM_RST_VEC    16'h0002
`define ASD_PM_WDT_VEC    16'h0004
`define ASD_PM_TRAP_VEC   16'h0006
`define ASD_PM_IRQ_VEC    16'h0008
`define ASD_PM_IRQ_END    16'h0037
`define ASD_PM_CODE_BASE  16'h0038
`define ASD_DM_ROM_BASE   16'hFF80
`define ASD_DM_ID_BASE    16'hFFC0
`define ASD_DM_ID_LEN     5'h14
`define ASD_UNDEF_BYTE    8'h00
`endif

// ### asd_decoder.sv
// decoder for register file, program memory and data memory spaces
// assumes the core presents one access per space per cycle, answered next cycle
`timescale 1ns/100ps
`default_nettype none
`include "asd_cfg.svh"
module asd_decoder
    import asd_pkg::*;
#(
    parameter logic [12:0] RAM_BYTES   = `ASD_RF_RAM_DEF,   // 2KB..4KB
    parameter logic [16:0] FLASH_BYTES = `ASD_PM_FLASH_DEF  // 16KB..64KB
)(
    input  wire logic        CLOCK,        // core clock
    input  wire logic        RST,          // synchronous reset, high
    input  wire logic        RF_REQ,       // register file access strobe
    input  wire logic        RF_WR,        // register file write
    input  wire logic [11:0] RF_ADDR,      // register file byte address
    input  wire logic [7:0]  RF_WDATA,     // register file write data
    input  wire logic        CTRL_HIT,     // peripheral claims control address
    input  wire logic [7:0]  CTRL_RDATA,   // peripheral read data
    output logic             RF_ACK,       // register file answer
    output logic [7:0]       RF_RDATA,     // register file read data
    output logic [1:0]       RF_SEL,       // register file region
    output logic             CTRL_WE,      // write to control register
    output logic             PM_REQ_OK,    // program request accepted
    input  wire logic        PM_REQ,       // program memory access strobe
    input  wire logic        PM_WR,        // program memory write
    input  wire logic [15:0] PM_ADDR,      // program memory address
    input  wire logic [7:0]  FLASH_RDATA,  // flash read data
    output logic             FLASH_RE,     // flash read enable
    output logic             FLASH_WE,     // flash write enable
    output logic             PM_ACK,       // program answer
    output logic [7:0]       PM_RDATA,     // program read data
    output logic [1:0]       PM_SEL,       // program region
    input  wire logic        DM_REQ,       // data memory access strobe
    input  wire logic        DM_WR,        // data memory write attempt
    input  wire logic [15:0] DM_ADDR,      // data memory address
    output logic             DM_ACK,       // data answer
    output logic [7:0]       DM_RDATA,     // data read data
    output logic [1:0]       DM_SEL        // data region
);
    logic [7:0]  ram [0:4095];
    logic        rf_ack_q, pm_ack_q, dm_ack_q;
    logic [1:0]  rf_sel_q, pm_sel_q, dm_sel_q;
    logic [7:0]  ram_q, ctrl_q;
    logic [7:0]  id_byte;
    asd_rf_sel_t rf_dec;
    asd_pm_sel_t pm_dec;
    asd_dm_sel_t dm_dec;
    asd_state_t  state;

    // register file region decode
    // 12-bit byte address
    function automatic asd_rf_sel_t rf_decode(input logic [11:0] a, input logic hit);
        if (a >= `ASD_RF_CTRL_BASE)
            return hit ? ASD_RF_CTRL : ASD_RF_RSVD;
        else if ({1'b0, a} < RAM_BYTES)
            return ASD_RF_RAM;
        else
            return ASD_RF_UNIMPL;
    endfunction : rf_decode

    // program memory region decode
    function automatic asd_pm_sel_t pm_decode(input logic [15:0] a);
        if ({1'b0, a} >= FLASH_BYTES)
            return ASD_PM_UNIMPL;
        else if (a < `ASD_PM_RST_VEC)
            return ASD_PM_OPTION;
        else if (a < `ASD_PM_CODE_BASE)
            return ASD_PM_VECTOR;
        else
            return ASD_PM_CODE;
    endfunction : pm_decode

    assign rf_dec = rf_decode(RF_ADDR, CTRL_HIT);
    assign pm_dec = pm_decode(PM_ADDR);
    assign dm_dec = (DM_ADDR >= `ASD_DM_ID_BASE
                     && DM_ADDR < `ASD_DM_ID_BASE + 16'(`ASD_DM_ID_LEN))
                    ? ASD_DM_ID : ASD_DM_RSVD;

    // peripheral write
    // control writes pass on; unclaimed ones reach no peripheral
    assign CTRL_WE  = RF_REQ && RF_WR && (rf_dec == ASD_RF_CTRL);
    assign FLASH_WE = PM_REQ && PM_WR && (pm_dec != ASD_PM_UNIMPL);
    assign FLASH_RE = PM_REQ && !PM_WR && (pm_dec != ASD_PM_UNIMPL);
    assign PM_REQ_OK = 1'b1;

    // ram write and registered ram read
    // writes to the gap and reserved area leave the ram contents alone
    always_ff @(posedge CLOCK)
    begin
        if (RF_REQ && RF_WR && rf_dec == ASD_RF_RAM)
            ram[RF_ADDR] <= RF_WDATA;
        ram_q <= ram[RF_ADDR];
    end

    // control read capture and region capture
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            rf_ack_q <= 1'b0;
            rf_sel_q <= 2'h0;
            ctrl_q   <= 8'h00;
        end
        else
        begin
            rf_ack_q <= RF_REQ;
            rf_sel_q <= rf_dec;
            ctrl_q   <= CTRL_RDATA;
        end
    end

    // program answer timing
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            pm_ack_q <= 1'b0;
            pm_sel_q <= 2'h3;
        end
        else
        begin
            pm_ack_q <= PM_REQ;
            pm_sel_q <= pm_dec;
        end
    end

    // data answer timing; writes are acknowledged but never stored
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            dm_ack_q <= 1'b0;
            dm_sel_q <= 2'h1;
        end
        else
        begin
            dm_ack_q <= DM_REQ;
            dm_sel_q <= dm_dec;
        end
    end

    // busy marker for any outstanding answer
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            state <= ASD_IDLE;
        else
            case (state)
                ASD_IDLE: state <= (RF_REQ || PM_REQ || DM_REQ) ? ASD_BUSY : ASD_IDLE;
                ASD_BUSY: state <= (RF_REQ || PM_REQ || DM_REQ) ? ASD_BUSY : ASD_IDLE;
                default:  state <= ASD_IDLE;
            endcase
    end

    asd_id_rom u_id (
        .CLOCK (CLOCK),
        .INDEX (DM_ADDR[4:0] - 5'(`ASD_DM_ID_BASE)),
        .DATA  (id_byte)
    );

    assign RF_ACK = rf_ack_q;
    assign RF_SEL = rf_sel_q;
    assign PM_ACK = pm_ack_q;
    assign PM_SEL = pm_sel_q;
    assign DM_ACK = dm_ack_q;
    assign DM_SEL = dm_sel_q;

    always_comb
    begin
        case (rf_sel_q)
            ASD_RF_RAM:  RF_RDATA = ram_q;
            ASD_RF_CTRL: RF_RDATA = ctrl_q;
            default:     RF_RDATA = `ASD_UNDEF_BYTE;
        endcase
        PM_RDATA = (pm_sel_q == ASD_PM_UNIMPL) ? `ASD_PM_BLANK : FLASH_RDATA;
        DM_RDATA = (dm_sel_q == ASD_DM_ID) ? id_byte : 8'h00;
    end

    // checks
    sequence s_pm_hole;
        PM_REQ && !PM_WR && ({1'b0, PM_ADDR} >= FLASH_BYTES);
    endsequence
    property p_pm_blank;
        @(posedge CLOCK) disable iff (RST) s_pm_hole |=> (PM_RDATA == 8'hFF && PM_ACK);
    endproperty
    a_pm_blank: assert property (p_pm_blank) else $error("blank flash read wrong");
    property p_pm_nowr;
        @(posedge CLOCK) disable iff (RST) (PM_WR && {1'b0, PM_ADDR} >= FLASH_BYTES) |-> !FLASH_WE;
    endproperty
    a_pm_nowr: assert property (p_pm_nowr) else $error("write past flash passed");
    property p_ctrl_top;
        @(posedge CLOCK) disable iff (RST) (RF_REQ && RF_ADDR >= 12'hF00) |=> RF_SEL inside {2'h1, 2'h2};
    endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control range as ram");
    property p_ram_low;
        @(posedge CLOCK) disable iff (RST)
            (RF_REQ && RF_ADDR < 12'hF00 && {1'b0, RF_ADDR} < RAM_BYTES) |=> RF_SEL == 2'h0;
    endproperty
    a_ram_low: assert property (p_ram_low) else $error("ram not selected");
    property p_gap;
        @(posedge CLOCK) disable iff (RST)
            (RF_REQ && RF_ADDR < 12'hF00 && {1'b0, RF_ADDR} >= RAM_BYTES) |=> RF_SEL == 2'h3;
    endproperty
    a_gap: assert property (p_gap) else $error("gap not unimplemented");
    property p_ctrl_we;
        @(posedge CLOCK) disable iff (RST) CTRL_WE |-> (RF_ADDR >= 12'hF00 && RF_WR);
    endproperty
    a_ctrl_we: assert property (p_ctrl_we) else $error("stray control write");
    property p_vec;
        @(posedge CLOCK) disable iff (RST)
            (PM_REQ && PM_ADDR >= 16'h0002 && PM_ADDR <= 16'h0037) |=> PM_SEL == 2'h1;
    endproperty
    a_vec: assert property (p_vec) else $error("vector area miss");
    property p_id;
        @(posedge CLOCK) disable iff (RST)
            (DM_REQ && DM_ADDR >= 16'hFFC0 && DM_ADDR <= 16'hFFD3) |=> DM_SEL == 2'h0;
    endproperty
    a_id: assert property (p_id) else $error("id area miss");
    property p_dm_rsvd;
        @(posedge CLOCK) disable iff (RST) (DM_REQ && DM_ADDR < 16'hFFC0) |=> DM_RDATA == 8'h00;
    endproperty
    a_dm_rsvd: assert property (p_dm_rsvd) else $error("reserved data nonzero");
    property p_busy;
        @(posedge CLOCK) disable iff (RST) (state == ASD_BUSY) |-> (RF_ACK || PM_ACK || DM_ACK);
    endproperty
    a_busy: assert property (p_busy) else $error("busy with no answer out");
endmodule : asd_decoder
`default_nettype wire

// ### asd_far_model.sv
// far-side model: flash array and peripheral register claims
// assumes the decoder's core clock and byte addresses
`timescale 1ns/100ps
`default_nettype none
module asd_far_model (
    input  wire logic        CLOCK,       // core clock
    input  wire logic [11:0] RF_ADDR,     // register file address
    output logic             CTRL_HIT,    // peripheral claim
    output logic [7:0]       CTRL_RDATA,  // peripheral data
    input  wire logic        FLASH_RE,    // flash read enable
    input  wire logic [15:0] PM_ADDR,     // flash address
    output var logic [7:0]   FLASH_RDATA  // flash data, next cycle
);
    // peripherals own F00-F05 and F07; F06 is left unclaimed
    assign CTRL_HIT   = (RF_ADDR[11:3] == 9'h1E0) && (RF_ADDR[2:0] != 3'h6);
    assign CTRL_RDATA = CTRL_HIT ? (RF_ADDR[7:0] ^ 8'h5A) : ~RF_ADDR[7:0];
    // flash answers a cycle after the enable, otherwise a toggling pattern
    always_ff @(posedge CLOCK)
    begin
        if (FLASH_RE)
            FLASH_RDATA <= PM_ADDR[7:0] ^ PM_ADDR[15:8] ^ 8'hC3;
        else
            FLASH_RDATA <= ~FLASH_RDATA;
    end
endmodule : asd_far_model
`default_nettype wire

// ### asd_id_rom.sv
// part-number string store for the read-only data memory area
// assumes index is already offset from the string base
`timescale 1ns/100ps
`default_nettype none
`include "asd_cfg.svh"
module asd_id_rom
    import asd_pkg::*;
#(
    // arbitrary value: "ASD001" followed by zero fill, 20 characters in all
    parameter logic [159:0] PART_STR = {48'h415344303031, 112'h0}
)(
    input  wire logic       CLOCK,  // core clock
    input  wire logic [4:0] INDEX,  // character index
    output logic      [7:0] DATA    // registered character
);
    // arbitrary part string, left-justified and zero-filled
    logic [7:0] chars [0:19];
    genvar g;
    generate
        for (g = 0; g < 20; g++)
        begin : g_chr
            assign chars[g] = PART_STR[159-8*g -: 8];
        end
    endgenerate
    // registered character read, zero past the string
    always_ff @(posedge CLOCK)
    begin
        DATA <= (INDEX < `ASD_DM_ID_LEN) ? chars[INDEX] : 8'h00;
    end
endmodule : asd_id_rom
`default_nettype wire

// ### asd_pkg.sv
// types shared by the address decoder files
// assumes asd_cfg.svh supplies the numeric map
package asd_pkg;
    typedef enum logic [1:0] {
        ASD_RF_RAM    = 2'h0,
        ASD_RF_CTRL   = 2'h1,
        ASD_RF_RSVD   = 2'h2,
        ASD_RF_UNIMPL = 2'h3
    } asd_rf_sel_t;
    typedef enum logic [1:0] {
        ASD_PM_OPTION = 2'h0,
        ASD_PM_VECTOR = 2'h1,
        ASD_PM_CODE   = 2'h2,
        ASD_PM_UNIMPL = 2'h3
    } asd_pm_sel_t;
    typedef enum logic [1:0] {
        ASD_DM_ID     = 2'h0,
        ASD_DM_RSVD   = 2'h1
    } asd_dm_sel_t;
    typedef enum logic [1:0] {
        ASD_IDLE = 2'h0,
        ASD_BUSY = 2'h1
    } asd_state_t;
endpackage : asd_pkg

// ### tb_top.sv
// self-checking bench for the three-space address decoder
// assumes asd_far_model stands in for flash and peripherals
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import asd_pkg::*;
    logic        CLOCK, RST, RF_REQ, RF_WR, CTRL_HIT, RF_ACK, CTRL_WE, PM_REQ_OK;
    logic        PM_REQ, PM_WR, FLASH_RE, FLASH_WE, PM_ACK, DM_REQ, DM_WR, DM_ACK;
    logic [11:0] RF_ADDR;
    logic [15:0] PM_ADDR, DM_ADDR;
    logic [7:0]  RF_WDATA, CTRL_RDATA, RF_RDATA, FLASH_RDATA, PM_RDATA, DM_RDATA, r_dat;
    logic [1:0]  RF_SEL, PM_SEL, DM_SEL, r_sel;
    logic        r_ack, r_strb;
    int          n_mismatch, n_compared;
    asd_decoder #(.RAM_BYTES(13'h0800), .FLASH_BYTES(17'h04000)) i_dut (
        .CLOCK(CLOCK), .RST(RST), .RF_REQ(RF_REQ), .RF_WR(RF_WR), .RF_ADDR(RF_ADDR),
        .RF_WDATA(RF_WDATA), .CTRL_HIT(CTRL_HIT), .CTRL_RDATA(CTRL_RDATA), .RF_ACK(RF_ACK),
        .RF_RDATA(RF_RDATA), .RF_SEL(RF_SEL), .CTRL_WE(CTRL_WE), .PM_REQ_OK(PM_REQ_OK),
        .PM_REQ(PM_REQ), .PM_WR(PM_WR), .PM_ADDR(PM_ADDR), .FLASH_RDATA(FLASH_RDATA),
        .FLASH_RE(FLASH_RE), .FLASH_WE(FLASH_WE), .PM_ACK(PM_ACK), .PM_RDATA(PM_RDATA),
        .PM_SEL(PM_SEL), .DM_REQ(DM_REQ), .DM_WR(DM_WR), .DM_ADDR(DM_ADDR),
        .DM_ACK(DM_ACK), .DM_RDATA(DM_RDATA), .DM_SEL(DM_SEL));
    asd_far_model i_far (.CLOCK(CLOCK), .RF_ADDR(RF_ADDR), .CTRL_HIT(CTRL_HIT),
        .CTRL_RDATA(CTRL_RDATA), .FLASH_RE(FLASH_RE), .PM_ADDR(PM_ADDR),
        .FLASH_RDATA(FLASH_RDATA));
    // clock at 5 ns period
    initial
    begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    // one comparison, counted and reported
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one access in space sp (0 rf, 1 pm, 2 dm); strobe seen mid-request
    task automatic acc(input int sp, input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        RF_REQ = (sp == 0); PM_REQ = (sp == 1); DM_REQ = (sp == 2);
        RF_WR = wr; PM_WR = wr; DM_WR = wr;
        RF_ADDR = a[11:0]; PM_ADDR = a; DM_ADDR = a; RF_WDATA = d;
        #1 r_strb = (sp == 0) ? CTRL_WE : (wr ? FLASH_WE : FLASH_RE);
        @(negedge CLOCK);
        r_ack = (sp == 0) ? RF_ACK : ((sp == 1) ? PM_ACK : DM_ACK);
        r_sel = (sp == 0) ? RF_SEL : ((sp == 1) ? PM_SEL : DM_SEL);
        r_dat = (sp == 0) ? RF_RDATA : ((sp == 1) ? PM_RDATA : DM_RDATA);
        RF_REQ = 1'b0; PM_REQ = 1'b0; DM_REQ = 1'b0;
        chk("ack", 8'h01, {7'h00, r_ack});
    endtask : acc
    // ram at the bottom, both ends of 2KB, gap above it
    task automatic t_ram;
        acc(0, 1, 16'h0000, 8'hA5); acc(0, 1, 16'h07FF, 8'h3C);
        acc(0, 1, 16'h0800, 8'h77);
        acc(0, 0, 16'h0000, 8'h00); chk("ram0", 8'hA5, r_dat);
        chk("ram0 sel", 8'h00, {6'h00, r_sel});
        acc(0, 0, 16'h07FF, 8'h00); chk("ram top", 8'h3C, r_dat);
        acc(0, 0, 16'h0800, 8'h00); chk("gap sel", 8'h03, {6'h00, r_sel});
        chk("gap data", 8'h00, r_dat);
        acc(0, 0, 16'h0EFF, 8'h00); chk("gap top sel", 8'h03, {6'h00, r_sel});
    endtask : t_ram
    // control range: claimed, unclaimed, and no aliasing into ram
    task automatic t_ctrl;
        acc(0, 1, 16'h0700, 8'h11);
        acc(0, 1, 16'h0F00, 8'h99); chk("ctrl we", 8'h01, {7'h00, r_strb});
        acc(0, 0, 16'h0700, 8'h00); chk("no alias", 8'h11, r_dat);
        acc(0, 0, 16'h0F07, 8'h00); chk("ctrl sel", 8'h01, {6'h00, r_sel});
        chk("ctrl data", 8'h07 ^ 8'h5A, r_dat);
        acc(0, 1, 16'h0F06, 8'h55); chk("rsvd we", 8'h00, {7'h00, r_strb});
        acc(0, 0, 16'h0F06, 8'h00); chk("rsvd sel", 8'h02, {6'h00, r_sel});
        chk("rsvd data", 8'h00, r_dat);
        acc(0, 0, 16'h0FFF, 8'h00); chk("top sel", 8'h02, {6'h00, r_sel});
    endtask : t_ctrl
    // program map regions, blank reads and dropped writes past flash
    task automatic t_pm;
        logic [15:0] pa [10] = '{16'h0000, 16'h0001, 16'h0002, 16'h0006, 16'h0008,
                                  16'h0037, 16'h0038, 16'h3FFF, 16'h4000, 16'hFFFF};
        logic [1:0]  ps [10] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
        for (int i = 0; i < 10; i++)
        begin
            acc(1, 0, pa[i], 8'h00);
            chk("pm sel", {6'h00, ps[i]}, {6'h00, r_sel});
            chk("pm re", {7'h00, i < 8}, {7'h00, r_strb});
            chk("pm data", (i < 8) ? pa[i][7:0] ^ pa[i][15:8] ^ 8'hC3 : 8'hFF, r_dat);
        end
        acc(1, 1, 16'h3FFF, 8'h00); chk("fl we", 8'h01, {7'h00, r_strb});
        acc(1, 1, 16'h4000, 8'h00); chk("blank we", 8'h00, {7'h00, r_strb});
        chk("pm ok", 8'h01, {7'h00, PM_REQ_OK});
    endtask : t_pm
    // part string, reserved data locations, ignored write
    task automatic t_dm;
        logic [47:0] s = "ASD001";
        acc(2, 1, 16'hFFC0, 8'h00);
        for (int i = 0; i < 20; i++)
        begin
            acc(2, 0, 16'hFFC0 + 16'(i), 8'h00);
            chk("id char", (i < 6) ? s[47 - 8 * i -: 8] : 8'h00, r_dat);
            chk("id sel", 8'h00, {6'h00, r_sel});
        end
        acc(2, 0, 16'hFFBF, 8'h00); chk("dm rsvd lo", 8'h01, {6'h00, r_sel});
        acc(2, 0, 16'hFFD4, 8'h00); chk("dm rsvd hi", 8'h01, {6'h00, r_sel});
        chk("dm rsvd data", 8'h00, r_dat);
    endtask : t_dm
    // counts, verdict and stop
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // watchdog against a hung run
    initial
    begin
        repeat (3000) @(posedge CLOCK);
        n_mismatch++;
        end_of_test();
    end
    // main sequence: reset, reset values, scenarios
    initial
    begin
        n_mismatch = 0; n_compared = 0; RST = 1'b1;
        RF_REQ = 1'b0; PM_REQ = 1'b0; DM_REQ = 1'b0; RF_WR = 1'b0; PM_WR = 1'b0;
        DM_WR = 1'b0; RF_ADDR = 12'h000; PM_ADDR = 16'h0000; DM_ADDR = 16'h0000;
        RF_WDATA = 8'h00;
        repeat (10) @(negedge CLOCK);
        chk("reset sels", 8'h0D, {2'h0, RF_SEL, PM_SEL, DM_SEL});
        chk("reset acks", 8'h00, {5'h00, RF_ACK, PM_ACK, DM_ACK});
        RST = 1'b0;
        t_ram();
        t_ctrl();
        t_pm();
        t_dm();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
